// ### inc/shf_field_pkg.sv
// shared constants and types for the shifter field deposit/extract block
// assumes a 40-bit register-file word whose fixed-point part sits in bits 39:8
package shf_field_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // apb register byte offsets
    localparam logic [7:0] ADDR_SRC_FX = 8'h00;
    localparam logic [7:0] ADDR_SRC_EXT = 8'h04;
    localparam logic [7:0] ADDR_DST_FX = 8'h08;
    localparam logic [7:0] ADDR_DST_EXT = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_IMM = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_POS_LSB = 7;   // start position in control word 12:7
    localparam int CTRL_LEN_LSB = 13;  // length in control word 18:13
    localparam int IMM_POS_LSB = 0;
    localparam int IMM_LEN_LSB = 8;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_IMM_BIT = 4;
    localparam int FX_LSB = 8;         // fixed-point part starts at word bit 8
    localparam int ST_BUSY_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [7:0] EXT_RST = 8'h00;
    localparam logic [5:0] FIELD_RST = 6'h00;
    localparam logic [6:0] FX_TOP = 7'h20;   // width of the fixed-point part
    localparam logic [5:0] LEN_MAX = 6'h20;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        OP_DEP_SE = 2'b00,
        OP_DEP_SE_OR = 2'b01,
        OP_EXT_ZF = 2'b10
    } field_op_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CALC = 1'b1
    } calc_state_e;

    typedef struct packed {
        logic sign;
        logic zero;
        logic overflow;
    } shf_flags_s;

endpackage : shf_field_pkg

// ### logic/field_datapath.sv
// combinational field deposit / extract datapath on 40-bit words
// assumes operands and field controls are stable for the cycle it is sampled
`timescale 1ns/1ps
module field_datapath (
    // operation
    input wire shf_field_pkg::field_op_e i_op,
    input wire logic [5:0] i_len,
    input wire logic [5:0] i_pos,
    // operands
    input wire logic [39:0] i_src,
    input wire logic [39:0] i_dst,
    // result
    output logic [39:0] o_result,
    output shf_field_pkg::shf_flags_s o_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // field shaping, sign extension and result select
    always_comb begin
        logic [5:0] eff_len;
        logic [6:0] top;
        logic [63:0] mask64;
        logic [63:0] placed;
        logic [63:0] msb_shift;
        logic [63:0] ext_mask;
        logic [63:0] pulled;
        logic [31:0] field;
        logic [31:0] dep_fx;
        logic msb;
        eff_len = (i_len > shf_field_pkg::LEN_MAX) ? shf_field_pkg::LEN_MAX : i_len;
        top = {1'b0, i_pos} + {1'b0, eff_len};
        mask64 = (64'h1 << eff_len) - 64'h1;
        field = i_src[39:shf_field_pkg::FX_LSB] & mask64[31:0];
        placed = {32'h0, field} << i_pos;
        msb_shift = placed >> (top - 7'h1);
        // no extension when the field top falls past bit 31
        msb = (eff_len != 6'h0) && (top <= shf_field_pkg::FX_TOP) && msb_shift[0];
        ext_mask = ~((64'h1 << top) - 64'h1);
        dep_fx = placed[31:0] | (msb ? ext_mask[31:0] : 32'h0);
        pulled = ({32'h0, i_src[39:shf_field_pkg::FX_LSB]} >> i_pos) & mask64;
        unique case (i_op)
            shf_field_pkg::OP_DEP_SE: begin
                o_result = {dep_fx, shf_field_pkg::EXT_RST};
            end
            shf_field_pkg::OP_DEP_SE_OR: begin
                o_result = {dep_fx, shf_field_pkg::EXT_RST} | i_dst;
            end
            shf_field_pkg::OP_EXT_ZF: begin
                o_result = {pulled[31:0], shf_field_pkg::EXT_RST};
            end
            default: begin
                o_result = i_dst;
            end
        endcase
        o_flags.sign = 1'b0;
        o_flags.zero = (o_result == 40'h00_0000_0000);
        o_flags.overflow = ({1'b0, i_len} + {1'b0, i_pos}) > shf_field_pkg::FX_TOP;
    end

endmodule : field_datapath

// ### logic/shifter_field_deposit_extract.sv
// shifter field unit: apb register front end around the field datapath
// assumes an apb3 master on i_core_clk; one command runs at a time
`timescale 1ns/1ps
module shifter_field_deposit_extract (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // result side
    output logic [39:0] o_result,
    output shf_field_pkg::shf_flags_s o_arith_status_word,
    output logic o_result_valid,
    output logic o_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0] src_fx_ff, nxt_src_fx;
    logic [7:0] src_ext_ff, nxt_src_ext;
    logic [31:0] dst_fx_ff, nxt_dst_fx;
    logic [7:0] dst_ext_ff, nxt_dst_ext;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [5:0] imm_len_ff, nxt_imm_len;
    logic [5:0] imm_pos_ff, nxt_imm_pos;
    shf_field_pkg::field_op_e op_ff, nxt_op;
    logic [5:0] field_length_ff, nxt_field_length;
    logic [5:0] field_start_pos_ff, nxt_field_start_pos;
    shf_field_pkg::calc_state_e state_ff, nxt_state;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [39:0] result_ff, nxt_result;
    shf_field_pkg::shf_flags_s flags_ff, nxt_flags;
    logic valid_ff, nxt_valid;

    logic [39:0] dp_result;
    shf_field_pkg::shf_flags_s dp_flags;
    logic access;
    logic wr_take;
    logic cmd_legal;
    logic cmd_go;

    ////////////////////////////////////////////////////////////////////////////
    // datapath on the latched command
    field_datapath u_datapath (
        .i_op(op_ff),
        .i_len(field_length_ff),
        .i_pos(field_start_pos_ff),
        .i_src({src_fx_ff, src_ext_ff}),
        .i_dst({dst_fx_ff, dst_ext_ff}),
        .o_result(dp_result),
        .o_flags(dp_flags)
    );

    // apb phase decode and command legality
    assign access = i_psel && i_penable && !pready_ff;
    assign wr_take = i_psel && i_penable && pready_ff && i_pwrite;
    assign cmd_legal = (i_pwdata[shf_field_pkg::CMD_OP_LSB +: 2] != 2'b11);
    assign cmd_go = wr_take && (i_paddr == shf_field_pkg::ADDR_CMD) && cmd_legal;

    ////////////////////////////////////////////////////////////////////////////
    // next values: apb answer, register writes, command sequencing
    always_comb begin
        nxt_src_fx = src_fx_ff;
        nxt_src_ext = src_ext_ff;
        nxt_dst_fx = dst_fx_ff;
        nxt_dst_ext = dst_ext_ff;
        nxt_ctrl = ctrl_ff;
        nxt_imm_len = imm_len_ff;
        nxt_imm_pos = imm_pos_ff;
        nxt_op = op_ff;
        nxt_field_length = field_length_ff;
        nxt_field_start_pos = field_start_pos_ff;
        nxt_state = state_ff;
        nxt_result = result_ff;
        nxt_flags = flags_ff;
        nxt_valid = 1'b0;
        nxt_pready = access;
        nxt_prdata = 32'h0;
        nxt_pslverr = 1'b0;
        // read data and error decided in the first access cycle
        if (access) begin
            unique case (i_paddr)
                shf_field_pkg::ADDR_SRC_FX: nxt_prdata = src_fx_ff;
                shf_field_pkg::ADDR_SRC_EXT: nxt_prdata = {24'h0, src_ext_ff};
                shf_field_pkg::ADDR_DST_FX: nxt_prdata = dst_fx_ff;
                shf_field_pkg::ADDR_DST_EXT: nxt_prdata = {24'h0, dst_ext_ff};
                shf_field_pkg::ADDR_CTRL: nxt_prdata = ctrl_ff;
                shf_field_pkg::ADDR_IMM: nxt_prdata = {18'h0, imm_len_ff, 2'h0, imm_pos_ff};
                shf_field_pkg::ADDR_CMD: begin
                    nxt_prdata = {27'h0, 1'b0, 2'h0, op_ff};
                    nxt_pslverr = i_pwrite && (i_pwdata[shf_field_pkg::CMD_OP_LSB +: 2] == 2'b11);
                end
                shf_field_pkg::ADDR_STATUS: begin
                    nxt_prdata = {28'h0, (state_ff == shf_field_pkg::ST_CALC), flags_ff};
                    nxt_pslverr = i_pwrite;
                end
                default: nxt_pslverr = 1'b1;
            endcase
        end
        // writes take effect on the edge that completes the transfer
        if (wr_take) begin
            unique case (i_paddr)
                shf_field_pkg::ADDR_SRC_FX: nxt_src_fx = i_pwdata;
                shf_field_pkg::ADDR_SRC_EXT: nxt_src_ext = i_pwdata[7:0];
                shf_field_pkg::ADDR_DST_FX: nxt_dst_fx = i_pwdata;
                shf_field_pkg::ADDR_DST_EXT: nxt_dst_ext = i_pwdata[7:0];
                shf_field_pkg::ADDR_CTRL: nxt_ctrl = i_pwdata;
                shf_field_pkg::ADDR_IMM: begin
                    nxt_imm_pos = i_pwdata[shf_field_pkg::IMM_POS_LSB +: 6];
                    nxt_imm_len = i_pwdata[shf_field_pkg::IMM_LEN_LSB +: 6];
                end
                default: begin
                    nxt_src_fx = src_fx_ff;
                end
            endcase
        end
        // command sequencing
        unique case (state_ff)
            shf_field_pkg::ST_IDLE: begin
                if (cmd_go) begin
                    nxt_op = shf_field_pkg::field_op_e'(i_pwdata[shf_field_pkg::CMD_OP_LSB +: 2]);
                    if (i_pwdata[shf_field_pkg::CMD_IMM_BIT]) begin
                        nxt_field_length = imm_len_ff;
                        nxt_field_start_pos = imm_pos_ff;
                    end else begin
                        nxt_field_length = ctrl_ff[shf_field_pkg::CTRL_LEN_LSB +: 6];
                        nxt_field_start_pos = ctrl_ff[shf_field_pkg::CTRL_POS_LSB +: 6];
                    end
                    nxt_state = shf_field_pkg::ST_CALC;
                end
            end
            shf_field_pkg::ST_CALC: begin
                // result goes back into the destination word
                nxt_dst_fx = dp_result[39:shf_field_pkg::FX_LSB];
                nxt_dst_ext = dp_result[7:0];
                nxt_result = dp_result;
                nxt_flags = dp_flags;
                nxt_valid = 1'b1;
                nxt_state = shf_field_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            src_fx_ff <= shf_field_pkg::WORD_RST;
            src_ext_ff <= shf_field_pkg::EXT_RST;
            dst_fx_ff <= shf_field_pkg::WORD_RST;
            dst_ext_ff <= shf_field_pkg::EXT_RST;
            ctrl_ff <= shf_field_pkg::WORD_RST;
            imm_len_ff <= shf_field_pkg::FIELD_RST;
            imm_pos_ff <= shf_field_pkg::FIELD_RST;
            op_ff <= shf_field_pkg::OP_DEP_SE;
            field_length_ff <= shf_field_pkg::FIELD_RST;
            field_start_pos_ff <= shf_field_pkg::FIELD_RST;
            state_ff <= shf_field_pkg::ST_IDLE;
            prdata_ff <= shf_field_pkg::WORD_RST;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            result_ff <= 40'h00_0000_0000;
            flags_ff <= 3'h0;
            valid_ff <= 1'b0;
        end else begin
            src_fx_ff <= nxt_src_fx;
            src_ext_ff <= nxt_src_ext;
            dst_fx_ff <= nxt_dst_fx;
            dst_ext_ff <= nxt_dst_ext;
            ctrl_ff <= nxt_ctrl;
            imm_len_ff <= nxt_imm_len;
            imm_pos_ff <= nxt_imm_pos;
            op_ff <= nxt_op;
            field_length_ff <= nxt_field_length;
            field_start_pos_ff <= nxt_field_start_pos;
            state_ff <= nxt_state;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            result_ff <= nxt_result;
            flags_ff <= nxt_flags;
            valid_ff <= nxt_valid;
        end
    end

    // outputs straight from flops
    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_result = result_ff;
    assign o_arith_status_word = flags_ff;
    assign o_result_valid = valid_ff;
    assign o_busy = (state_ff == shf_field_pkg::ST_CALC);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    ctrl_field_take_a: assert property (cmd_go && !i_pwdata[shf_field_pkg::CMD_IMM_BIT] |=>
        field_start_pos_ff == $past(ctrl_ff[12:7]) && field_length_ff == $past(ctrl_ff[18:13]))
        else $error("control word fields not taken from 12:7 and 18:13");

    dep_ovf_flag_a: assert property (valid_ff && op_ff != shf_field_pkg::OP_EXT_ZF |->
        flags_ff.overflow == (({1'b0, field_length_ff} + {1'b0, field_start_pos_ff}) > 7'h20))
        else $error("deposit overflow flag wrong");

    ext_ovf_flag_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_EXT_ZF |->
        flags_ff.overflow == (({1'b0, field_length_ff} + {1'b0, field_start_pos_ff}) > 7'h20))
        else $error("extract overflow flag wrong");

    zero_sign_flag_a: assert property ($rose(valid_ff) |->
        !flags_ff.sign && flags_ff.zero == (result_ff == 40'h0) && o_arith_status_word == flags_ff)
        else $error("sign or zero flag wrong");

    ext_byte_clear_a: assert property (valid_ff && op_ff != shf_field_pkg::OP_DEP_SE_OR |->
        result_ff[7:0] == 8'h00)
        else $error("extension byte not cleared");

    below_field_zero_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_DEP_SE |->
        (result_ff[39:8] & ((32'h1 << field_start_pos_ff) - 32'h1)) == 32'h0
        || field_start_pos_ff > 6'h1f)
        else $error("bits below deposited field not zero");

    or_keeps_dst_a: assert property (state_ff == shf_field_pkg::ST_CALC
        && op_ff == shf_field_pkg::OP_DEP_SE_OR ##1 valid_ff |->
        ({dst_fx_ff, dst_ext_ff} & $past({dst_fx_ff, dst_ext_ff})) == $past({dst_fx_ff, dst_ext_ff}))
        else $error("or deposit lost prior destination bits");

    dep_lsb_place_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_DEP_SE
        && field_length_ff != 6'h0 && field_start_pos_ff < 6'h20 |->
        ((result_ff[39:8] >> field_start_pos_ff) & 32'h1) == ($past(src_fx_ff, 2) & 32'h1))
        else $error("field lsb not placed at start position");

    sign_ext_top_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_DEP_SE
        && field_length_ff != 6'h0 && field_length_ff < 6'h20
        && ({1'b0, field_length_ff} + {1'b0, field_start_pos_ff}) < 7'h20 |->
        result_ff[39] == (($past(src_fx_ff, 2) >> (field_length_ff - 6'h1)) & 32'h1) != 32'h0)
        else $error("sign extension wrong");

    ext_right_just_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_EXT_ZF
        && field_length_ff < 6'h20 |->
        result_ff[39:8] == (($past(src_fx_ff, 2) >> field_start_pos_ff)
        & ((32'h1 << field_length_ff) - 32'h1)))
        else $error("extracted field wrong");

    // lengths above 32 must act as a full 32-bit field
    len_clamp_a: assert property (valid_ff && op_ff == shf_field_pkg::OP_EXT_ZF
        && field_length_ff > 6'h20 && field_start_pos_ff == 6'h0 |->
        result_ff[39:8] == $past(src_fx_ff, 2))
        else $error("length above 32 not handled as 32");

    apb_ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready held more than one cycle");

endmodule : shifter_field_deposit_extract

// ### dv/apb_host_model.sv
// apb master standing in for the core side that loads operands and commands
// assumes callers enter xfer right after a rising edge of i_clk
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input wire logic i_clk,
    // slave answer
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    // request
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one transfer: setup, access held until pready, release with garbage
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        @(posedge i_clk);
        while (i_pready !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        rd = i_prdata;
        err = i_pslverr;
        ok = (n < 50);
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a; // released lines do not keep the last value
        o_pwdata <= ~d;
    endtask : xfer
endmodule : apb_host_model

// ### dv/testbench.sv
// self-checking bench: integer reference of deposit/extract against the design
// assumes the design package and the apb host model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic i_core_clk;
    logic i_arst_n;
    logic psel, penable, pwrite, pready, pslverr, valid, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [39:0] result;
    shf_field_pkg::shf_flags_s flags;
    int failures, tests_run, cycles;

    ////////////////////////////////////////////////////////////////////////////
    // design and bus host
    shifter_field_deposit_extract dut_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_result(result), .o_arith_status_word(flags),
        .o_result_valid(valid), .o_busy(busy));
    apb_host_model host_u (.i_clk(i_core_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // xorshift stimulus source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // reference result: ops 0 deposit se, 1 deposit se or, 2 extract zero-fill
    function automatic logic [39:0] ref_op(input int op, input logic [39:0] s, input logic [39:0] d,
                                           input int len, input int pos, output logic [2:0] fl);
        int l;
        logic [31:0] fx;
        logic [39:0] res;
        l = (len > 32) ? 32 : len;
        fx = 32'h0;
        for (int i = 0; i < l; i++) begin
            if (pos + i < 32 && op == 2) fx[i] = s[8 + pos + i];
            if (pos + i < 32 && op != 2) fx[pos + i] = s[8 + i];
        end
        if (op != 2 && l > 0 && pos + l <= 32 && s[8 + l - 1]) begin
            for (int i = pos + l; i < 32; i++) fx[i] = 1'b1;
        end
        res = {fx, 8'h00};
        if (op == 1) res = res | d;
        fl = {1'b0, res == 40'h0, (len + pos) > 32};
        return res;
    endfunction : ref_op

    ////////////////////////////////////////////////////////////////////////////
    // bus wrapper, command run and verdict
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic err);
        logic ok;
        @(posedge i_core_clk);
        host_u.xfer(wr, a, d, rd, err, ok);
        if (ok !== 1'b1) begin
            failures++;
            report_and_stop();
        end
    endtask : bus

    task automatic run_op(input int op, input logic [39:0] s, input logic [39:0] d,
                          input int len, input int pos, input logic imm);
        logic [39:0] ex;
        logic [2:0] fl;
        logic e;
        ex = ref_op(op, s, d, len, pos, fl);
        bus(1'b1, shf_field_pkg::ADDR_SRC_FX, s[39:8], e);
        bus(1'b1, shf_field_pkg::ADDR_SRC_EXT, {24'h0, s[7:0]}, e);
        bus(1'b1, shf_field_pkg::ADDR_DST_FX, d[39:8], e);
        bus(1'b1, shf_field_pkg::ADDR_DST_EXT, {24'h0, d[7:0]}, e);
        if (imm) bus(1'b1, shf_field_pkg::ADDR_IMM, {18'h0, len[5:0], 2'h0, pos[5:0]}, e);
        else bus(1'b1, shf_field_pkg::ADDR_CTRL, (rnd() & 32'hfff8_007f) | {13'h0, len[5:0], pos[5:0], 7'h0}, e);
        bus(1'b1, shf_field_pkg::ADDR_CMD, {27'h0, imm, 2'h0, op[1:0]}, e);
        `CHK(e, 1'b0)
        // busy rises on the completing edge itself, result follows one edge later
        #1;
        `CHK(busy, 1'b1)
        @(posedge i_core_clk);
        #1;
        `CHK(valid, 1'b1)
        if (op == 0) `CHK(result[39:8], ex[39:8])
        if (op == 1) `CHK(result, ex)
        if (op == 2) `CHK(result[39:8], ex[39:8])
        if (op != 1) `CHK(result[7:0], 8'h00)
        `CHK(flags.zero, fl[1])
        `CHK(flags.sign, 1'b0)
        `CHK(flags.overflow, fl[0])
        bus(1'b0, shf_field_pkg::ADDR_DST_FX, 32'h0, e);
        `CHK(rd, ex[39:8])
        bus(1'b0, shf_field_pkg::ADDR_STATUS, 32'h0, e);
        `CHK(rd, {29'h0, fl})
    endtask : run_op

    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, corner table, random sweep, refusals
    initial begin
        int lens[7] = '{0, 32, 14, 1, 33, 20, 8};
        int poss[7] = '{0, 0, 13, 31, 0, 20, 63};
        logic e;
        logic [39:0] held;
        i_core_clk = 1'b0;
        i_arst_n = 1'b0;
        seed = 32'h50af;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        repeat (2) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        #1;
        `CHK({result, busy, valid, pready}, 43'h0)
        for (int op = 0; op < 3; op++) begin
            for (int k = 0; k < 7; k++) begin
                run_op(op, {rnd(), 8'(rnd())}, {rnd(), 8'(rnd())}, lens[k], poss[k], k[0]);
            end
        end
        for (int k = 0; k < 40; k++) begin
            // half the sweep keeps the start position below 24 to exercise sign extension
            run_op(int'(rnd() % 3), {rnd(), 8'(rnd())}, {rnd(), 8'(rnd())}, int'(rnd() % 64),
                   k[0] ? int'(rnd() % 64) : int'(rnd() % 24), 1'(rnd()));
        end
        held = result;
        bus(1'b0, 8'h20, 32'h0, e);
        `CHK({e, rd}, {1'b1, 32'h0})
        bus(1'b1, shf_field_pkg::ADDR_STATUS, 32'hf, e);
        `CHK(e, 1'b1)
        bus(1'b1, shf_field_pkg::ADDR_CMD, 32'h3, e);
        `CHK(e, 1'b1)
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK({busy, result}, {1'b0, held})
        report_and_stop();
    end
endmodule : testbench
